// ==== core/subset_exec.sv ====
// Instruction subset executor with APB register access
//
// Functional notes
// - Bit clear zeroes one chosen bit of memory byte, flags untouched.
// - Watchdog kick resets watchdog and clears timeout and power-down flags.
// - Memory invert writes complement back, updates only zero flag.
// - Invert-to-work puts complement in working register, memory kept, zero only.
// - Decimal adjust adds six to low nibble if above nine or aux carry.
// - Decimal adjust adds six to high nibble if above nine or carry.
// - Decimal adjust touches only carry, set on decimal overflow past hundred.
// - Memory decrement stores byte minus one back, updates zero flag.
// - Decrement-to-work loads byte minus one into working register, zero flag.
// - Power-down stops execution, keeps memory and registers.
// - Power-down resets watchdog and prescaler, sets power-down, clears timeout.
// - Memory increment stores byte plus one back, updates zero flag.
// - Increment-to-work loads byte plus one into working register, zero flag.
// - Jump loads program counter, takes one extra dummy cycle (three in all), changes no flag.
// - Load move copies memory byte to working register, no flags.
// - Immediate move loads operand into working register, no flags.
// - Store move writes working register into memory byte, no flags.
`timescale 1ns/1ns
`default_nettype none
module subset_exec
  import exec_pkg::*;
#(
  parameter int MEM_DEPTH = exec_pkg::MEM_D
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [exec_pkg::PADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output var  logic [31:0]                 prdata,
  output var  logic                        pready,
  output var  logic                        pslverr
);
  import exec_pkg::*;

  initial begin
    if (MEM_DEPTH < 1 || MEM_DEPTH > (1 << ADDR_W)) begin
      $error("subset_exec: memory depth out of range");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  core_state_s r;
  core_state_s next_r;

  logic [DATA_W-1:0] mem_rdata;
  logic              mem_we;
  logic [ADDR_W-1:0] mem_waddr;
  logic [DATA_W-1:0] mem_wdata;
  logic [ADDR_W-1:0] mem_raddr;

  logic access;
  logic in_mem;
  logic busy;
  logic apb_commit;
  logic [ADDR_W-1:0] win_addr;

  assign access     = psel & penable;
  assign in_mem     = (paddr[11:8] == MEM_PAGE) && (paddr[1:0] == 2'b00);
  assign busy       = (r.st != ST_IDLE);
  assign win_addr   = paddr[ADDR_W+1:2];
  // Write side effects happen only at the edge where the master sees pready
  assign apb_commit = r.pready & access & pwrite & ~r.pslverr;

  data_ram #(
    .WIDTH(DATA_W),
    .DEPTH(MEM_DEPTH),
    .AW   (ADDR_W)
  ) u_ram (
    .pclk (pclk),
    .we   (mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // Operand fetch owns the read port; bus reads use it only while idle
  assign mem_raddr = (r.st == ST_FETCH) ? r.addr : win_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Decimal adjust datapath
  logic [8:0] daa_low;
  logic [8:0] daa_full;
  logic       daa_carry;

  always_comb begin
    daa_low = {1'b0, r.working_register};
    if (r.working_register[3:0] > BCD_MAX || r.aux_carry_flag) begin
      daa_low = {1'b0, r.working_register} + ADJ_LOW;
    end
    daa_full = daa_low;
    if (daa_low[7:4] > BCD_MAX || r.carry_flag || daa_low[8]) begin
      daa_full = {1'b0, daa_low[7:0]} + ADJ_HIGH;
    end
    // Carry only ever set, so chained adds keep a prior overflow
    daa_carry = r.carry_flag | daa_low[8] | daa_full[8];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [7:0] res;
    logic [7:0] bmask;
    logic       pre_wrap;
    logic       tout_evt;
    res       = 8'h00;
    tout_evt  = 1'b0;
    bmask     = 8'h01 << r.bsel;
    pre_wrap  = 1'b0;
    next_r    = r;
    mem_we    = 1'b0;
    mem_waddr = r.addr;
    mem_wdata = 8'h00;

    // Watchdog runs only while the core clock is on
    if (!r.halted) begin
      next_r.wd_prescaler = r.wd_prescaler + 8'h01;
      pre_wrap = (r.wd_prescaler == 8'hFF);
      if (pre_wrap) begin
        next_r.watchdog_counter = r.watchdog_counter + 8'h01;
      end
    end

    unique case (r.st)
      ST_IDLE: begin
      end
      ST_FETCH: begin
        next_r.st = ST_EXEC;
      end
      ST_EXEC: begin
        next_r.st = ST_IDLE;
        next_r.pc = r.pc + 10'h001;
        case (r.op)
          bit_clear_op: begin
            mem_we    = 1'b1;
            mem_wdata = mem_rdata & ~bmask;
          end
          watchdog_kick_op: begin
            next_r.wd_prescaler     = 8'h00;
            next_r.watchdog_counter = 8'h00;
            next_r.timeout_flag     = 1'b0;
            next_r.powerdown_flag   = 1'b0;
          end
          bit_invert_op: begin
            res       = ~mem_rdata;
            mem_we    = 1'b1;
            mem_wdata = res;
            next_r.zero_flag = (res == 8'h00);
          end
          invert_to_work_op: begin
            res = ~mem_rdata;
            next_r.working_register = res;
            next_r.zero_flag = (res == 8'h00);
          end
          decimal_adjust_op: begin
            mem_we    = 1'b1;
            mem_wdata = daa_full[7:0];
            next_r.carry_flag = daa_carry;
          end
          minus_one_op: begin
            res       = mem_rdata - 8'h01;
            mem_we    = 1'b1;
            mem_wdata = res;
            next_r.zero_flag = (res == 8'h00);
          end
          minus_one_to_work_op: begin
            res = mem_rdata - 8'h01;
            next_r.working_register = res;
            next_r.zero_flag = (res == 8'h00);
          end
          power_down_op: begin
            next_r.halted           = 1'b1;
            next_r.wd_prescaler     = 8'h00;
            next_r.watchdog_counter = 8'h00;
            next_r.powerdown_flag   = 1'b1;
            next_r.timeout_flag     = 1'b0;
          end
          plus_one_op: begin
            res       = mem_rdata + 8'h01;
            mem_we    = 1'b1;
            mem_wdata = res;
            next_r.zero_flag = (res == 8'h00);
          end
          plus_one_to_work_op: begin
            res = mem_rdata + 8'h01;
            next_r.working_register = res;
            next_r.zero_flag = (res == 8'h00);
          end
          jump_op: begin
            next_r.pc = r.operand;
            next_r.st = ST_DUMMY;
          end
          copy_op: begin
            next_r.working_register = mem_rdata;
          end
          copy_imm_op: begin
            next_r.working_register = r.operand[7:0];
          end
          copy_store_op: begin
            mem_we    = 1'b1;
            mem_wdata = r.working_register;
          end
          default: begin
            // Unassigned codes only advance the program counter
          end
        endcase
      end
      ST_DUMMY: begin
        next_r.st = ST_IDLE;
      end
      default: begin
        next_r.st = ST_IDLE;
      end
    endcase

    // Timeout event beats any clear in the same cycle
    tout_evt = !r.halted && pre_wrap && (r.watchdog_counter == 8'hFF);
    if (tout_evt) begin
      next_r.timeout_flag = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, two for memory reads, more for memory accesses while busy
    if (r.pready) begin
      next_r.pready  = 1'b0;
      next_r.pslverr = 1'b0;
      if (apb_commit) begin
        if (in_mem) begin
          mem_we    = 1'b1;
          mem_waddr = win_addr;
          mem_wdata = pwdata[7:0];
        end else begin
          unique case (paddr)
            OFS_INSTR: begin
              next_r.st      = ST_FETCH;
              next_r.op      = pwdata[INS_OP_LSB +: 4];
              next_r.bsel    = pwdata[INS_BIT_LSB +: 3];
              next_r.addr    = pwdata[INS_ADR_LSB +: ADDR_W];
              next_r.operand = pwdata[INS_OPD_LSB +: PC_W];
            end
            OFS_WORK: begin
              next_r.working_register = pwdata[7:0];
            end
            OFS_FLAGS: begin
              next_r.zero_flag      = pwdata[FLG_ZERO];
              next_r.carry_flag     = pwdata[FLG_CARRY];
              next_r.aux_carry_flag = pwdata[FLG_AUX];
              // Software may clear, but a same-cycle timeout wins
              next_r.timeout_flag   = pwdata[FLG_TOUT] | tout_evt;
              next_r.powerdown_flag = pwdata[FLG_PDF];
            end
            OFS_WAKE: begin
              next_r.halted = r.halted & ~pwdata[0];
            end
            default: begin
            end
          endcase
        end
      end
    end else if (access) begin
      next_r.prdata = 32'h0000_0000;
      if (in_mem) begin
        if (pwrite) begin
          next_r.pready = ~busy;
        end else if (!busy && !r.mem_pend) begin
          next_r.mem_pend = 1'b1;
        end else if (r.mem_pend) begin
          next_r.mem_pend    = 1'b0;
          next_r.pready      = 1'b1;
          next_r.prdata[7:0] = mem_rdata;
        end
      end else begin
        next_r.pready = 1'b1;
        unique case (paddr)
          OFS_INSTR: begin
            next_r.pslverr = pwrite & (busy | r.halted);
            next_r.prdata[INS_OP_LSB +: 4]       = r.op;
            next_r.prdata[INS_BIT_LSB +: 3]      = r.bsel;
            next_r.prdata[INS_ADR_LSB +: ADDR_W] = r.addr;
            next_r.prdata[INS_OPD_LSB +: PC_W]   = r.operand;
          end
          OFS_WORK: begin
            next_r.pslverr     = pwrite & busy;
            next_r.prdata[7:0] = r.working_register;
          end
          OFS_FLAGS: begin
            next_r.pslverr = pwrite & busy;
            next_r.prdata[FLG_ZERO]  = r.zero_flag;
            next_r.prdata[FLG_CARRY] = r.carry_flag;
            next_r.prdata[FLG_AUX]   = r.aux_carry_flag;
            next_r.prdata[FLG_TOUT]  = r.timeout_flag;
            next_r.prdata[FLG_PDF]   = r.powerdown_flag;
          end
          OFS_PC: begin
            next_r.pslverr = pwrite;
            next_r.prdata[PC_W-1:0] = r.pc;
          end
          OFS_STATUS: begin
            next_r.pslverr = pwrite;
            next_r.prdata[STS_BUSY]          = busy;
            next_r.prdata[STS_HALTED]        = r.halted;
            next_r.prdata[STS_PRE_LSB +: 8]  = r.wd_prescaler;
            next_r.prdata[STS_WD_LSB +: 8]   = r.watchdog_counter;
          end
          OFS_WAKE: begin
          end
          default: begin
            next_r.pslverr = 1'b1;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r                  <= '0;
      r.st               <= ST_IDLE;
      r.working_register <= WORK_RST;
      r.pc               <= PC_RST;
    end else begin
      r <= next_r;
    end
  end

  assign prdata  = r.prdata;
  assign pready  = r.pready;
  assign pslverr = r.pslverr;

endmodule : subset_exec
`default_nettype wire

// ==== shared/exec_pkg.sv ====
// Constants, encodings and state types for the instruction subset executor
`default_nettype none
package exec_pkg;

  localparam int DATA_W  = 8;
  localparam int MEM_D   = 64;
  localparam int ADDR_W  = 6;
  localparam int PC_W    = 10;
  localparam int PADDR_W = 12;

  // Register byte offsets
  localparam logic [11:0] OFS_INSTR  = 12'h000;
  localparam logic [11:0] OFS_WORK   = 12'h004;
  localparam logic [11:0] OFS_FLAGS  = 12'h008;
  localparam logic [11:0] OFS_PC     = 12'h00C;
  localparam logic [11:0] OFS_STATUS = 12'h010;
  localparam logic [11:0] OFS_WAKE   = 12'h014;
  // Data memory window, one byte per word
  localparam logic [3:0]  MEM_PAGE   = 4'h1;

  // Instruction word fields
  localparam int INS_OP_LSB  = 0;
  localparam int INS_BIT_LSB = 4;
  localparam int INS_ADR_LSB = 8;
  localparam int INS_OPD_LSB = 16;

  // Flag register fields
  localparam int FLG_ZERO = 0;
  localparam int FLG_CARRY = 1;
  localparam int FLG_AUX  = 2;
  localparam int FLG_TOUT = 3;
  localparam int FLG_PDF  = 4;

  // Status register fields
  localparam int STS_BUSY   = 0;
  localparam int STS_HALTED = 1;
  localparam int STS_PRE_LSB = 8;
  localparam int STS_WD_LSB  = 16;

  // Reset values
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [9:0] PC_RST   = 10'h000;

  // Decimal adjust constants
  localparam logic [3:0] BCD_MAX   = 4'h9;
  localparam logic [8:0] ADJ_LOW   = 9'h006;
  localparam logic [8:0] ADJ_HIGH  = 9'h060;

  typedef enum logic [3:0] {
    bit_clear_op         = 4'h0,
    watchdog_kick_op     = 4'h1,
    bit_invert_op        = 4'h2,
    invert_to_work_op    = 4'h3,
    decimal_adjust_op    = 4'h4,
    minus_one_op         = 4'h5,
    minus_one_to_work_op = 4'h6,
    power_down_op        = 4'h7,
    plus_one_op          = 4'h8,
    plus_one_to_work_op  = 4'h9,
    jump_op              = 4'hA,
    copy_op              = 4'hB,
    copy_imm_op          = 4'hC,
    copy_store_op        = 4'hD
  } op_e;

  // Gray coded: idle, fetch, execute, dummy
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC  = 2'b11,
    ST_DUMMY = 2'b10
  } exec_state_e;

  typedef struct packed {
    exec_state_e        st;
    logic [3:0]         op;
    logic [2:0]         bsel;
    logic [ADDR_W-1:0]  addr;
    logic [PC_W-1:0]    operand;
    logic [DATA_W-1:0]  working_register;
    logic               zero_flag;
    logic               carry_flag;
    logic               aux_carry_flag;
    logic               timeout_flag;
    logic               powerdown_flag;
    logic               halted;
    logic [PC_W-1:0]    pc;
    logic [7:0]         wd_prescaler;
    logic [7:0]         watchdog_counter;
    logic               pready;
    logic               pslverr;
    logic               mem_pend;
    logic [31:0]        prdata;
  } core_state_s;

endpackage : exec_pkg
`default_nettype wire

// ==== core/data_ram.sv ====
// Byte-wide data memory with registered read port
`timescale 1ns/1ns
`default_nettype none
module data_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic             pclk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output var  logic [WIDTH-1:0] rdata
);

  initial begin
    if (DEPTH > (1 << AW) || WIDTH < 1) begin
      $error("data_ram: depth does not fit address width");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];

  // No reset: contents survive reset and power-down alike
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : data_ram
`default_nettype wire

// ==== test/exec_chk.sv ====
// Bus-level checker for the instruction subset executor
`timescale 1ns/1ns
`default_nettype none
module exec_chk
  import exec_pkg::*;
#(
  parameter int MEM_DEPTH = exec_pkg::MEM_D
) (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [exec_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0]                  pwdata,
  input wire logic [31:0]                  prdata,
  input wire logic                         pready,
  input wire logic                         pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable) else $error("pready outside access");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  // Worst case is a memory access behind a jump
  a_ready_bound: assert property ($rose(penable) && psel |-> ##[0:8] pready)
    else $error("no pready in time");
  a_pc_readonly: assert property (pready && pwrite && paddr == OFS_PC |-> pslverr)
    else $error("pc write accepted");
  a_status_ro: assert property (pready && pwrite && paddr == OFS_STATUS |-> pslverr)
    else $error("status write accepted");
  a_wake_taken: assert property (pready && paddr == OFS_WAKE |-> !pslverr)
    else $error("wake refused");
  a_hole_zero: assert property (pready && !pwrite && paddr == 12'h020 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_mem_upper: assert property (pready && !pwrite && paddr[11:8] == MEM_PAGE
    |-> prdata[31:8] == 24'h0) else $error("memory read upper bits set");
endmodule : exec_chk
bind subset_exec exec_chk #(.MEM_DEPTH(MEM_DEPTH)) u_exec_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ==== test/apb_host.sv ====
// Host-side register bus master model
`timescale 1ns/1ns
`default_nettype none
module apb_host (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // Answer latency is never assumed; a wait ends on pready or at the 40-cycle bound
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Look half a cycle early so the sampling edge is race free
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) begin
      tb.miscompares++;
      tb.tally_and_finish();
    end
    @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : apb_host
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking testbench for the instruction subset executor
`timescale 1ns/1ns
`default_nettype none
module tb;
  import exec_pkg::*;
  logic             pclk;
  logic             presetn;
  wire logic        psel, penable, pwrite, pready, pslverr;
  wire logic [11:0] paddr;
  wire logic [31:0] pwdata, prdata;
  int               miscompares = 0;
  int               n_tests = 0;

  subset_exec u_subset_exec (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  apb_host u_apb_host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [11:0] ma(input logic [5:0] a);
    return {MEM_PAGE, a, 2'b00};
  endfunction : ma

  task automatic wre(input logic [11:0] a, input logic [31:0] d, input logic ex);
    logic [31:0] q;
    logic        e;
    u_apb_host.xfer(1'b1, a, d, q, e);
    chk({31'h0, e}, {31'h0, ex});
  endtask : wre

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    u_apb_host.xfer(1'b1, a, d, q, e);
  endtask : wr

  task automatic rdq(input logic [11:0] a, output logic [31:0] q);
    logic e;
    u_apb_host.xfer(1'b0, a, 32'h0000_0000, q, e);
  endtask : rdq

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    rdq(a, q);
    chk(q, exp);
  endtask : rd

  task automatic run(input op_e op, input logic [2:0] b, input logic [5:0] adr,
                     input logic [9:0] opd);
    logic [31:0] q;
    int          n;
    n = 0;
    wr(OFS_INSTR, {6'h00, opd, 2'b00, adr, 1'b0, b, op});
    do begin
      rdq(OFS_STATUS, q);
      // One idle bus cycle apart: only a jump is still busy here
      if (n == 0) chk({31'h0, q[0]}, {31'h0, (op == jump_op)});
      n++;
    end while (q[0] !== 1'b0 && n < 20);
    if (q[0] !== 1'b0) begin
      miscompares++;
      tally_and_finish();
    end
  endtask : run
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_bits;
    wr(ma(6'd5), 32'h0000_00ff);
    wr(OFS_FLAGS, 32'h0000_0007);
    run(bit_clear_op, 3'd3, 6'd5, 10'h000);
    rd(ma(6'd5), 32'h0000_00f7);
    rd(OFS_FLAGS, 32'h0000_0007);
    run(bit_invert_op, 3'd0, 6'd5, 10'h000);
    rd(ma(6'd5), 32'h0000_0008);
    rd(OFS_FLAGS, 32'h0000_0006);
    run(invert_to_work_op, 3'd0, 6'd5, 10'h000);
    rd(OFS_WORK, 32'h0000_00f7);
    rd(ma(6'd5), 32'h0000_0008);
    rd(OFS_FLAGS, 32'h0000_0006);
  endtask : t_bits

  task automatic t_count;
    wr(ma(6'd7), 32'h0000_0001);
    run(minus_one_op, 3'd0, 6'd7, 10'h000);
    rd(ma(6'd7), 32'h0000_0000);
    rd(OFS_FLAGS, 32'h0000_0007);
    run(minus_one_to_work_op, 3'd0, 6'd7, 10'h000);
    rd(OFS_WORK, 32'h0000_00ff);
    rd(ma(6'd7), 32'h0000_0000);
    rd(OFS_FLAGS, 32'h0000_0006);
    run(plus_one_op, 3'd0, 6'd7, 10'h000);
    rd(ma(6'd7), 32'h0000_0001);
    run(plus_one_to_work_op, 3'd0, 6'd7, 10'h000);
    rd(OFS_WORK, 32'h0000_0002);
    rd(ma(6'd7), 32'h0000_0001);
    rd(OFS_FLAGS, 32'h0000_0006);
    wr(ma(6'd7), 32'h0000_00ff);
    run(plus_one_op, 3'd0, 6'd7, 10'h000);
    rd(ma(6'd7), 32'h0000_0000);
    rd(OFS_FLAGS, 32'h0000_0007);
  endtask : t_count

  // Zero stays set throughout to show adjust leaves it alone
  task automatic t_adjust;
    logic [7:0] w[5] = '{8'h0b, 8'h02, 8'ha2, 8'h12, 8'h9a};
    logic [7:0] fi[5] = '{8'h01, 8'h05, 8'h01, 8'h03, 8'h01};
    logic [7:0] mo[5] = '{8'h11, 8'h08, 8'h02, 8'h72, 8'h00};
    logic [7:0] fo[5] = '{8'h01, 8'h05, 8'h03, 8'h03, 8'h03};
    for (int i = 0; i < 5; i++) begin
      wr(OFS_WORK, {24'h0, w[i]});
      wr(OFS_FLAGS, {24'h0, fi[i]});
      run(decimal_adjust_op, 3'd0, 6'd8, 10'h000);
      rd(ma(6'd8), {24'h0, mo[i]});
      rd(OFS_FLAGS, {24'h0, fo[i]});
    end
  endtask : t_adjust

  task automatic t_move;
    wr(OFS_FLAGS, 32'h0000_0007);
    run(copy_imm_op, 3'd0, 6'd0, 10'h05a);
    rd(OFS_WORK, 32'h0000_005a);
    run(copy_store_op, 3'd0, 6'd9, 10'h000);
    rd(ma(6'd9), 32'h0000_005a);
    wr(ma(6'd10), 32'h0000_00c3);
    run(copy_op, 3'd0, 6'd10, 10'h000);
    rd(OFS_WORK, 32'h0000_00c3);
    rd(OFS_FLAGS, 32'h0000_0007);
    run(jump_op, 3'd0, 6'd0, 10'h2ab);
    rd(OFS_PC, 32'h0000_02ab);
    rd(OFS_FLAGS, 32'h0000_0007);
    run(copy_imm_op, 3'd0, 6'd0, 10'h011);
    rd(OFS_PC, 32'h0000_02ac);
  endtask : t_move

  task automatic t_sleep;
    logic [31:0] q;
    wr(ma(6'd11), 32'h0000_003c);
    run(power_down_op, 3'd0, 6'd0, 10'h000);
    rd(OFS_STATUS, 32'h0000_0002);
    rd(OFS_FLAGS, 32'h0000_0017);
    wre(OFS_INSTR, {20'h0, 8'h00, copy_imm_op}, 1'b1);
    rd(OFS_WORK, 32'h0000_0011);
    rd(ma(6'd11), 32'h0000_003c);
    wre(OFS_WAKE, 32'h0000_0001, 1'b0);
    // Watchdog must count before the kick
    repeat (300) @(posedge pclk);
    rdq(OFS_STATUS, q);
    chk({24'h0, q[23:16]}, 32'h0000_0001);
    run(watchdog_kick_op, 3'd0, 6'd0, 10'h000);
    rd(OFS_FLAGS, 32'h0000_0007);
    rdq(OFS_STATUS, q);
    chk({24'h0, q[23:16]}, 32'h0000_0000);
    wre(OFS_PC, 32'h0000_0000, 1'b1);
    wre(OFS_STATUS, 32'h0000_0000, 1'b1);
    rd(12'h020, 32'h0000_0000);
  endtask : t_sleep
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_bits();
    t_count();
    t_adjust();
    t_move();
    t_sleep();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
